/* File: orl_defs.svh */
// offsets, field positions, reset values and sizes of the event latch block
`ifndef ORL_DEFS_SVH
`define ORL_DEFS_SVH

`define ORL_OFS_TRACE_CTRL 8'h75
`define ORL_OFS_TRACE_DATA 8'h76
`define ORL_OFS_LINE_CFG 8'h77
`define ORL_OFS_SRC_RG 8'hA0
`define ORL_OFS_SRC_RGMUX 8'hA1
`define ORL_OFS_SRC_MUX 8'hA2
`define ORL_OFS_SRC_PROT 8'hA3
`define ORL_OFS_SRC_ADAPT 8'hA4
`define ORL_OFS_ST_RG 8'hC0
`define ORL_OFS_ST_MUX 8'hC1
`define ORL_OFS_ST_PROT 8'hC3
`define ORL_OFS_ST_ADAPT 8'hC4
`define ORL_OFS_RX_K1 8'h00
`define ORL_OFS_RX_K2 8'h01
`define ORL_OFS_RX_S1 8'h02
`define ORL_OFS_PROT_K1 8'h22
`define ORL_OFS_PROT_K2 8'h23
`define ORL_OFS_RX_C2 8'h83
`define ORL_OFS_RX_K3 8'h84

`define ORL_TRACE_CTRL_ACC 1
`define ORL_TRACE_CTRL_PRST 0
`define ORL_LINE_CFG_SERIAL 0
`define ORL_LINE_CFG_B3ZS 1

`define ORL_RST_TRACE_CTRL 8'h02
`define ORL_RST_LINE_CFG 8'h00
`define ORL_RST_SRC 8'h00
`define ORL_RST_TRACE_DATA 8'h00
`define ORL_TRACE_IDLE_BYTE 8'h01
`define ORL_TRACE_DEPTH 64

`define ORL_CNT_FSLIP 0
`define ORL_CNT_B1 1
`define ORL_CNT_B2BIT 2
`define ORL_CNT_B2BLK 3
`define ORL_CNT_REIBIT 4
`define ORL_CNT_REIBLK 5
`define ORL_CNT_PDEC 6
`define ORL_CNT_PINC 7
`define ORL_CNT_NUM 8

`define ORL_NUM_BYTES 7
`define ORL_BYTE_K1 0
`define ORL_BYTE_K2 1
`define ORL_BYTE_S1 2
`define ORL_BYTE_PK1 3
`define ORL_BYTE_PK2 4
`define ORL_BYTE_C2 5
`define ORL_BYTE_K3 6

`endif

/* File: orl_pkg.sv */
// types shared by the event latch block
package orl_pkg;
  typedef logic [7:0] orl_byte_t;
  typedef enum logic [1:0] {
    ORL_POL_NONE,
    ORL_POL_POS,
    ORL_POL_NEG
  } orl_pol_t;
endpackage

/* File: orl_trace_string.sv */
// transmit path trace string store with its byte pointer
`timescale 1ns/1ps
`include "orl_defs.svh"
module orl_trace_string #(
  parameter int DEPTH = `ORL_TRACE_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire orl_pkg::orl_byte_t cpu_wdata_i,
  input wire logic cpu_access_i,
  input wire logic ptr_reset_i,
  input wire logic tx_slot_i,
  output orl_pkg::orl_byte_t cpu_rdata_o,
  output orl_pkg::orl_byte_t tx_byte_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  orl_pkg::orl_byte_t mem_ff [DEPTH];
  orl_pkg::orl_byte_t tx_byte_ff;
  logic [AW-1:0] ptr_ff;
  logic prst_prev_ff;
  logic prst_edge;
  logic step;

  assign prst_edge = ptr_reset_i & ~prst_prev_ff;
  // software steps the pointer in access mode, the frame slot otherwise
  assign step = cpu_access_i ? (cpu_wr_i | cpu_rd_i) : tx_slot_i;
  assign cpu_rdata_o = mem_ff[ptr_ff];
  assign tx_byte_o = tx_byte_ff;

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prst_prev_ff <= 1'b0;
    end else begin
      prst_prev_ff <= ptr_reset_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ptr_ff <= '0;
    end else if (prst_edge) begin
      ptr_ff <= '0;
    end else if (step) begin
      ptr_ff <= (ptr_ff == LAST) ? '0 : ptr_ff + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= `ORL_RST_TRACE_DATA;
      end
    end else if (cpu_access_i && cpu_wr_i) begin
      mem_ff[ptr_ff] <= cpu_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_byte_ff <= `ORL_TRACE_IDLE_BYTE;
    end else if (cpu_access_i) begin
      tx_byte_ff <= `ORL_TRACE_IDLE_BYTE;
    end else if (tx_slot_i) begin
      tx_byte_ff <= mem_ff[ptr_ff];
    end
  end
endmodule // orl_trace_string

/* File: orl_event_latches.sv */
// receive overhead event latches, interrupt output and trace data port
`timescale 1ns/1ps
`include "orl_defs.svh"
module orl_event_latches #(
  parameter int TRACE_DEPTH = `ORL_TRACE_DEPTH
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [2:0] regen_status_i,
  input wire logic [5:0] mux_status_i,
  input wire logic [3:0] adapt_status_i,
  input wire logic [`ORL_CNT_NUM-1:0] cnt_wrap_i,
  input wire logic [`ORL_CNT_NUM-1:0] cnt_read_i,
  input wire logic [7:0] rx_aps_byte1_i,
  input wire logic [7:0] rx_aps_byte2_i,
  input wire logic [7:0] rx_sync_status_i,
  input wire logic [7:0] protect_aps_byte1_i,
  input wire logic [7:0] protect_aps_byte2_i,
  input wire logic [7:0] rx_signal_label_i,
  input wire logic [7:0] rx_path_aps_byte_i,
  input wire logic protect_fail_input_i,
  input wire logic protect_degrade_input_i,
  input wire logic line_bit_en_i,
  input wire logic rx_line_positive_rail_i,
  input wire logic rx_line_negative_rail_i,
  input wire logic [7:0] irq_enable_rg_i,
  input wire logic [7:0] irq_enable_rgmux_i,
  input wire logic [7:0] irq_enable_mux_i,
  input wire logic [7:0] irq_enable_prot_i,
  input wire logic [7:0] irq_enable_adapt_i,
  input wire logic trace_tx_slot_i,
  output logic [7:0] trace_tx_byte_o,
  output logic irq_o
);
  // clear-on-read latch update: a set in the clearing cycle wins
  function automatic logic [7:0] latch_upd(input logic [7:0] cur,
                                           input logic [7:0] set,
                                           input logic [7:0] clr);
    return (cur & ~clr) | set;
  endfunction

  function automatic logic rd_at(input logic rd,
                                 input logic [7:0] addr,
                                 input logic [7:0] ofs);
    return rd & (addr == ofs);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0] src_rg_ff;
  logic [7:0] src_rgmux_ff;
  logic [7:0] src_mux_ff;
  logic [7:0] src_prot_ff;
  logic [7:0] src_adapt_ff;
  logic [7:0] trace_ctrl_ff;
  logic [7:0] line_cfg_ff;
  logic [7:0] rdata_ff;
  logic irq_ff;

  // change detection history
  logic primed_ff;
  logic [2:0] regen_prev_ff;
  logic [5:0] mux_prev_ff;
  logic [3:0] adapt_prev_ff;
  logic [1:0] prot_prev_ff;
  orl_pkg::orl_byte_t byte_prev_ff [`ORL_NUM_BYTES];
  orl_pkg::orl_byte_t byte_cur [`ORL_NUM_BYTES];
  logic [`ORL_NUM_BYTES-1:0] byte_chg;
  logic [2:0] regen_chg;
  logic [5:0] mux_chg;
  logic [3:0] adapt_chg;
  logic [1:0] prot_chg;

  // line violation tracking
  orl_pkg::orl_pol_t last_pol_ff;
  logic [1:0] zeros_ff;
  logic bpv_en;
  logic bpv;

  // bus decode
  logic rd_src_rg, rd_st_rg, rd_st_mux, rd_st_prot, rd_st_adapt;
  logic rd_k1, rd_k2, rd_s1, rd_pk1, rd_pk2, rd_c2, rd_k3;
  logic wr_trace, rd_trace;
  orl_pkg::orl_byte_t trace_rdata;
  logic [7:0] rd_mux;

  //////////////////////////////////////////////////////////////////////////
  // address decode
  assign rd_src_rg = rd_at(reg_rd_i, reg_addr_i, `ORL_OFS_SRC_RG);
  assign rd_st_rg = rd_at(reg_rd_i, reg_addr_i, `ORL_OFS_ST_RG);
  assign rd_st_mux = rd_at(reg_rd_i, reg_addr_i, `ORL_OFS_ST_MUX);
  assign rd_st_prot = rd_at(reg_rd_i, reg_addr_i, `ORL_OFS_ST_PROT);
  assign rd_st_adapt = rd_at(reg_rd_i, reg_addr_i, `ORL_OFS_ST_ADAPT);
  assign rd_k1 = rd_at(reg_rd_i, reg_addr_i, `ORL_OFS_RX_K1);
  assign rd_k2 = rd_at(reg_rd_i, reg_addr_i, `ORL_OFS_RX_K2);
  assign rd_s1 = rd_at(reg_rd_i, reg_addr_i, `ORL_OFS_RX_S1);
  assign rd_pk1 = rd_at(reg_rd_i, reg_addr_i, `ORL_OFS_PROT_K1);
  assign rd_pk2 = rd_at(reg_rd_i, reg_addr_i, `ORL_OFS_PROT_K2);
  assign rd_c2 = rd_at(reg_rd_i, reg_addr_i, `ORL_OFS_RX_C2);
  assign rd_k3 = rd_at(reg_rd_i, reg_addr_i, `ORL_OFS_RX_K3);
  assign rd_trace = rd_at(reg_rd_i, reg_addr_i, `ORL_OFS_TRACE_DATA);
  assign wr_trace = reg_wr_i & (reg_addr_i == `ORL_OFS_TRACE_DATA);

  //////////////////////////////////////////////////////////////////////////
  // change detectors; the first cycle after reset only loads history
  assign byte_cur[`ORL_BYTE_K1] = rx_aps_byte1_i;
  assign byte_cur[`ORL_BYTE_K2] = rx_aps_byte2_i;
  assign byte_cur[`ORL_BYTE_S1] = rx_sync_status_i;
  assign byte_cur[`ORL_BYTE_PK1] = protect_aps_byte1_i;
  assign byte_cur[`ORL_BYTE_PK2] = protect_aps_byte2_i;
  assign byte_cur[`ORL_BYTE_C2] = rx_signal_label_i;
  assign byte_cur[`ORL_BYTE_K3] = rx_path_aps_byte_i;

  always_comb begin
    for (int i = 0; i < `ORL_NUM_BYTES; i++) begin
      byte_chg[i] = primed_ff & (byte_cur[i] != byte_prev_ff[i]);
    end
  end

  assign regen_chg = {3{primed_ff}} & (regen_status_i ^ regen_prev_ff);
  assign mux_chg = {6{primed_ff}} & (mux_status_i ^ mux_prev_ff);
  assign adapt_chg = {4{primed_ff}} & (adapt_status_i ^ adapt_prev_ff);
  assign prot_chg = {2{primed_ff}} &
    ({protect_fail_input_i, protect_degrade_input_i} ^ prot_prev_ff);

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      primed_ff <= 1'b0;
      regen_prev_ff <= 3'h0;
      mux_prev_ff <= 6'h00;
      adapt_prev_ff <= 4'h0;
      prot_prev_ff <= 2'h0;
      for (int i = 0; i < `ORL_NUM_BYTES; i++) begin
        byte_prev_ff[i] <= 8'h00;
      end
    end else begin
      primed_ff <= 1'b1;
      regen_prev_ff <= regen_status_i;
      mux_prev_ff <= mux_status_i;
      adapt_prev_ff <= adapt_status_i;
      prot_prev_ff <= {protect_fail_input_i, protect_degrade_input_i};
      for (int i = 0; i < `ORL_NUM_BYTES; i++) begin
        byte_prev_ff[i] <= byte_cur[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // bipolar violation: same polarity as the last pulse, except a B3ZS
  // substitution pulse which follows one or two zero slots
  assign bpv_en = line_cfg_ff[`ORL_LINE_CFG_SERIAL] &
                  line_cfg_ff[`ORL_LINE_CFG_B3ZS];

  always_comb begin
    bpv = 1'b0;
    if (bpv_en && line_bit_en_i) begin
      if (rx_line_positive_rail_i && rx_line_negative_rail_i) begin
        bpv = 1'b1;
      end else if ((zeros_ff != 2'd1) && (zeros_ff != 2'd2)) begin
        bpv = (rx_line_positive_rail_i &&
               last_pol_ff == orl_pkg::ORL_POL_POS) ||
              (rx_line_negative_rail_i &&
               last_pol_ff == orl_pkg::ORL_POL_NEG);
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      last_pol_ff <= orl_pkg::ORL_POL_NONE;
      zeros_ff <= 2'd0;
    end else if (!bpv_en) begin
      last_pol_ff <= orl_pkg::ORL_POL_NONE;
      zeros_ff <= 2'd0;
    end else if (line_bit_en_i) begin
      if (rx_line_positive_rail_i && !rx_line_negative_rail_i) begin
        last_pol_ff <= orl_pkg::ORL_POL_POS;
        zeros_ff <= 2'd0;
      end else if (rx_line_negative_rail_i && !rx_line_positive_rail_i) begin
        last_pol_ff <= orl_pkg::ORL_POL_NEG;
        zeros_ff <= 2'd0;
      end else if (zeros_ff != 2'd3) begin
        zeros_ff <= zeros_ff + 2'd1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // event source latches; reserved bits have no set term and stay zero
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      src_rg_ff <= `ORL_RST_SRC;
    end else begin
      src_rg_ff <= latch_upd(src_rg_ff,
        {cnt_wrap_i[`ORL_CNT_FSLIP], cnt_wrap_i[`ORL_CNT_B1], 2'b00,
         bpv, regen_chg},
        {cnt_read_i[`ORL_CNT_FSLIP], cnt_read_i[`ORL_CNT_B1], 2'b00,
         rd_src_rg, {3{rd_st_rg}}});
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      src_rgmux_ff <= `ORL_RST_SRC;
    end else begin
      src_rgmux_ff <= latch_upd(src_rgmux_ff,
        {byte_chg[`ORL_BYTE_K1], byte_chg[`ORL_BYTE_K2], mux_chg},
        {rd_k1, rd_k2, {6{rd_st_mux}}});
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      src_mux_ff <= `ORL_RST_SRC;
    end else begin
      src_mux_ff <= latch_upd(src_mux_ff,
        {3'b000, byte_chg[`ORL_BYTE_S1],
         cnt_wrap_i[`ORL_CNT_B2BIT], cnt_wrap_i[`ORL_CNT_B2BLK],
         cnt_wrap_i[`ORL_CNT_REIBIT], cnt_wrap_i[`ORL_CNT_REIBLK]},
        {3'b000, rd_s1,
         cnt_read_i[`ORL_CNT_B2BIT], cnt_read_i[`ORL_CNT_B2BLK],
         cnt_read_i[`ORL_CNT_REIBIT], cnt_read_i[`ORL_CNT_REIBLK]});
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      src_prot_ff <= `ORL_RST_SRC;
    end else begin
      src_prot_ff <= latch_upd(src_prot_ff,
        {4'h0, prot_chg,
         byte_chg[`ORL_BYTE_PK1], byte_chg[`ORL_BYTE_PK2]},
        {4'h0, {2{rd_st_prot}}, rd_pk1, rd_pk2});
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      src_adapt_ff <= `ORL_RST_SRC;
    end else begin
      src_adapt_ff <= latch_upd(src_adapt_ff,
        {adapt_chg[3:1], cnt_wrap_i[`ORL_CNT_PDEC],
         cnt_wrap_i[`ORL_CNT_PINC], adapt_chg[0],
         byte_chg[`ORL_BYTE_C2], byte_chg[`ORL_BYTE_K3]},
        {{3{rd_st_adapt}}, cnt_read_i[`ORL_CNT_PDEC],
         cnt_read_i[`ORL_CNT_PINC], rd_st_adapt, rd_c2, rd_k3});
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt output; protection enables are software's to keep low
  // unless this unit is a protection main
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(src_rg_ff & irq_enable_rg_i) |
                |(src_rgmux_ff & irq_enable_rgmux_i) |
                |(src_mux_ff & irq_enable_mux_i) |
                |(src_prot_ff & irq_enable_prot_i) |
                |(src_adapt_ff & irq_enable_adapt_i);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // writable control registers; source registers ignore writes
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trace_ctrl_ff <= `ORL_RST_TRACE_CTRL;
    end else if (reg_wr_i && reg_addr_i == `ORL_OFS_TRACE_CTRL) begin
      trace_ctrl_ff <= {6'h00, reg_wdata_i[1:0]};
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      line_cfg_ff <= `ORL_RST_LINE_CFG;
    end else if (reg_wr_i && reg_addr_i == `ORL_OFS_LINE_CFG) begin
      line_cfg_ff <= {6'h00, reg_wdata_i[1:0]};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // trace string store
  orl_trace_string #(
    .DEPTH(TRACE_DEPTH)
  ) u_trace (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .cpu_wr_i(wr_trace),
    .cpu_rd_i(rd_trace),
    .cpu_wdata_i(reg_wdata_i),
    .cpu_access_i(trace_ctrl_ff[`ORL_TRACE_CTRL_ACC]),
    .ptr_reset_i(trace_ctrl_ff[`ORL_TRACE_CTRL_PRST]),
    .tx_slot_i(trace_tx_slot_i),
    .cpu_rdata_o(trace_rdata),
    .tx_byte_o(trace_tx_byte_o)
  );

  //////////////////////////////////////////////////////////////////////////
  // read data, valid only in the cycle after the strobe
  always_comb begin
    unique case (reg_addr_i)
      `ORL_OFS_TRACE_CTRL: rd_mux = trace_ctrl_ff;
      `ORL_OFS_TRACE_DATA: rd_mux = trace_rdata;
      `ORL_OFS_LINE_CFG: rd_mux = line_cfg_ff;
      `ORL_OFS_SRC_RG: rd_mux = src_rg_ff;
      `ORL_OFS_SRC_RGMUX: rd_mux = src_rgmux_ff;
      `ORL_OFS_SRC_MUX: rd_mux = src_mux_ff;
      `ORL_OFS_SRC_PROT: rd_mux = src_prot_ff;
      `ORL_OFS_SRC_ADAPT: rd_mux = src_adapt_ff;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= reg_rd_i ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign irq_o = irq_ff;
endmodule // orl_event_latches

/* File: orl_event_latches_monitor.sv */
// concurrent checks on the ports of the event latch block
`timescale 1ns/1ps
module orl_event_latches_monitor (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [2:0] regen_status_i,
  input wire logic [5:0] mux_status_i,
  input wire logic [3:0] adapt_status_i,
  input wire logic [7:0] cnt_wrap_i,
  input wire logic [7:0] cnt_read_i,
  input wire logic [7:0] rx_aps_byte1_i,
  input wire logic protect_fail_input_i,
  input wire logic [7:0] irq_enable_rg_i,
  input wire logic [7:0] irq_enable_rgmux_i,
  input wire logic [7:0] irq_enable_mux_i,
  input wire logic [7:0] irq_enable_prot_i,
  input wire logic [7:0] irq_enable_adapt_i,
  input wire logic [7:0] trace_tx_byte_o,
  input wire logic irq_o
);
  logic acc_ff;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // shadow of the trace access mode bit
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_ff <= 1'b1;
    end else if (reg_wr_i && reg_addr_i == 8'h75) begin
      acc_ff <= reg_wdata_i[1];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  rdata_idle_a:
    assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  rg_reserved_a:
    assert property ($past(reg_rd_i && reg_addr_i == 8'hA0) |->
      reg_rdata_o[5:4] == 2'b00) else $error("reserved bits set");
  prot_reserved_a:
    assert property ($past(reg_rd_i && reg_addr_i == 8'hA3) |->
      reg_rdata_o[7:4] == 4'h0) else $error("reserved bits set");
  irq_mask_a:
    assert property ($past({irq_enable_rg_i, irq_enable_rgmux_i,
      irq_enable_mux_i, irq_enable_prot_i, irq_enable_adapt_i}) == 40'h0
      |-> !irq_o) else $error("interrupt with all enables off");
  regen_set_a:
    assert property ($changed(regen_status_i) ##1
      (reg_rd_i && reg_addr_i == 8'hA0) |=> reg_rdata_o[2:0] != 3'h0)
    else $error("regenerator change not latched");
  mux_set_a:
    assert property ($changed(mux_status_i) ##1
      (reg_rd_i && reg_addr_i == 8'hA1) |=> reg_rdata_o[5:0] != 6'h00)
    else $error("multiplexer change not latched");
  adapt_set_a:
    assert property ($changed(adapt_status_i) ##1
      (reg_rd_i && reg_addr_i == 8'hA4) |=>
      {reg_rdata_o[7:5], reg_rdata_o[2]} != 4'h0)
    else $error("adaptation change not latched");
  aps_byte_a:
    assert property ($changed(rx_aps_byte1_i) ##1
      (reg_rd_i && reg_addr_i == 8'hA1) |=> reg_rdata_o[7])
    else $error("byte change not latched");
  prot_edge_a:
    assert property ($changed(protect_fail_input_i) ##1
      (reg_rd_i && reg_addr_i == 8'hA3) |=> reg_rdata_o[3])
    else $error("protection edge not latched");
  mux_wrap_a:
    assert property (cnt_wrap_i[2] ##1 (reg_rd_i && reg_addr_i == 8'hA2)
      |=> reg_rdata_o[3]) else $error("counter wrap not latched");
  wrap_keep_a:
    assert property (cnt_wrap_i[1] && cnt_read_i[1] ##1
      (reg_rd_i && reg_addr_i == 8'hA0) |=> reg_rdata_o[6])
    else $error("event lost in clearing cycle");
  trace_idle_a:
    assert property (acc_ff && $past(acc_ff) |-> trace_tx_byte_o == 8'h01)
    else $error("access mode byte wrong");
endmodule // orl_event_latches_monitor

bind orl_event_latches orl_event_latches_monitor u_mon (.ref_clk_i,
  .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .regen_status_i, .mux_status_i, .adapt_status_i, .cnt_wrap_i, .cnt_read_i,
  .rx_aps_byte1_i, .protect_fail_input_i, .irq_enable_rg_i,
  .irq_enable_rgmux_i, .irq_enable_mux_i, .irq_enable_prot_i,
  .irq_enable_adapt_i, .trace_tx_byte_o, .irq_o);

/* File: orl_cpu_model.sv */
// microprocessor model driving the register port
`timescale 1ns/1ps
module orl_cpu_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // released lines show the inverse so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr_o <= a;
    reg_wdata_o <= v;
    reg_wr_o <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~v;
    @(posedge ref_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge ref_clk_i);
    v = reg_rdata_i;
  endtask
endmodule // orl_cpu_model

/* File: orl_event_latches_test.sv */
// self-checking bench of the event latch block
`timescale 1ns/1ps
module orl_event_latches_test;
  typedef struct {logic [3:0] k; logic [7:0] a, e, c, m;} orl_row_t;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr, wdata, rdata, d, tx_byte;
  logic wr, rd, irq_o;
  logic bit_en = 1'b0, pos = 1'b0, neg = 1'b0, slot = 1'b0;
  logic pf = 1'b0, pd = 1'b0;
  logic [2:0] rg_st = 3'h0;
  logic [5:0] mx_st = 6'h0;
  logic [3:0] ad_st = 4'h0;
  logic [7:0] wrap = 8'h00, rdc = 8'h00;
  logic [7:0] by [7] = '{default: 8'h00};
  logic [7:0] en [5] = '{default: 8'h00};
  logic [7:0] ra [6] = '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'h76};
  orl_row_t r;
  // kind 0..6 byte registers, 7 regen, 8 mux, 9 prot, A adapt, F wraps
  orl_row_t rows [14] = '{
    '{4'h7, 8'hA0, 8'h07, 8'hC0, 8'h00}, '{4'hF, 8'hA0, 8'hC0, 8'hFF, 8'h03},
    '{4'h8, 8'hA1, 8'h3F, 8'hC1, 8'h00}, '{4'h0, 8'hA1, 8'h80, 8'h00, 8'h00},
    '{4'h1, 8'hA1, 8'h40, 8'h01, 8'h00}, '{4'h2, 8'hA2, 8'h10, 8'h02, 8'h00},
    '{4'hF, 8'hA2, 8'h0F, 8'hFF, 8'h3C}, '{4'h9, 8'hA3, 8'h0C, 8'hC3, 8'h00},
    '{4'h3, 8'hA3, 8'h02, 8'h22, 8'h00}, '{4'h4, 8'hA3, 8'h01, 8'h23, 8'h00},
    '{4'hA, 8'hA4, 8'hE4, 8'hC4, 8'h00}, '{4'hF, 8'hA4, 8'h18, 8'hFF, 8'hC0},
    '{4'h5, 8'hA4, 8'h02, 8'h83, 8'h00}, '{4'h6, 8'hA4, 8'h01, 8'h84, 8'h00}};
  int errors = 0;
  int checks = 0;
  int cycles = 0;

  orl_cpu_model u_cpu (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdata),
    .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
  orl_event_latches #(.TRACE_DEPTH(4)) u_dut (.ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .regen_status_i(rg_st),
    .mux_status_i(mx_st), .adapt_status_i(ad_st), .cnt_wrap_i(wrap),
    .cnt_read_i(rdc), .rx_aps_byte1_i(by[0]), .rx_aps_byte2_i(by[1]),
    .rx_sync_status_i(by[2]), .protect_aps_byte1_i(by[3]),
    .protect_aps_byte2_i(by[4]), .rx_signal_label_i(by[5]),
    .rx_path_aps_byte_i(by[6]), .protect_fail_input_i(pf),
    .protect_degrade_input_i(pd), .line_bit_en_i(bit_en),
    .rx_line_positive_rail_i(pos), .rx_line_negative_rail_i(neg),
    .irq_enable_rg_i(en[0]), .irq_enable_rgmux_i(en[1]),
    .irq_enable_mux_i(en[2]), .irq_enable_prot_i(en[3]),
    .irq_enable_adapt_i(en[4]), .trace_tx_slot_i(slot),
    .trace_tx_byte_o(tx_byte), .irq_o(irq_o));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // five line slots, slot 0 in bit 0 of each rail pattern
  task automatic bpv(input logic [7:0] cfg, input logic [4:0] p,
                     input logic [4:0] n, input logic [7:0] exp);
    u_cpu.wr(8'h77, cfg);
    for (int i = 0; i < 5; i++) begin
      pos <= p[i];
      neg <= n[i];
      bit_en <= 1'b1;
      @(posedge ref_clk_i);
    end
    pos <= 1'b0;
    neg <= 1'b0;
    bit_en <= 1'b0;
    u_cpu.rd(8'hA0, d);
    chk(d, exp);
  endtask
  task automatic slot_pulse(input logic [7:0] exp);
    slot <= 1'b1;
    @(posedge ref_clk_i);
    slot <= 1'b0;
    @(posedge ref_clk_i);
    chk(tx_byte, exp);
  endtask

  initial begin
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    chk({7'h00, irq_o}, 8'h00);
    chk(tx_byte, 8'h01);
    foreach (ra[i]) begin
      u_cpu.rd(ra[i], d);
      chk(d, 8'h00);
    end
    foreach (rows[i]) begin
      r = rows[i];
      if (r.k < 4'h7) by[r.k] <= ~by[r.k];
      else if (r.k == 4'h7) rg_st <= ~rg_st;
      else if (r.k == 4'h8) mx_st <= ~mx_st;
      else if (r.k == 4'h9) begin
        pf <= ~pf;
        pd <= ~pd;
      end else if (r.k == 4'hA) ad_st <= ~ad_st;
      else wrap <= r.m;
      @(posedge ref_clk_i);
      wrap <= 8'h00;
      u_cpu.rd(r.a, d);
      chk(d, r.e);
      // the bench acts as a protection main unit
      en[r.a[2:0]] <= ~r.e;
      repeat (2) @(posedge ref_clk_i);
      chk({7'h00, irq_o}, 8'h00);
      en[r.a[2:0]] <= r.e;
      repeat (2) @(posedge ref_clk_i);
      chk({7'h00, irq_o}, 8'h01);
      en[r.a[2:0]] <= 8'h00;
      if (r.c == 8'hFF) begin
        rdc <= r.m;
        @(posedge ref_clk_i);
        rdc <= 8'h00;
      end else begin
        u_cpu.rd(r.c, d);
      end
      u_cpu.rd(r.a, d);
      chk(d, 8'h00);
    end
    wrap <= 8'h02;
    rdc <= 8'h02;
    @(posedge ref_clk_i);
    wrap <= 8'h00;
    rdc <= 8'h00;
    u_cpu.rd(8'hA0, d);
    chk(d, 8'h40);
    u_cpu.wr(8'hA0, 8'hFF);
    rdc <= 8'h02;
    @(posedge ref_clk_i);
    rdc <= 8'h00;
    u_cpu.rd(8'hA0, d);
    chk(d, 8'h00);
    u_cpu.rd(8'h50, d);
    chk(d, 8'h00);
    bpv(8'h01, 5'h01, 5'h01, 8'h00);
    bpv(8'h03, 5'h09, 5'h00, 8'h00);
    bpv(8'h03, 5'h01, 5'h01, 8'h08);
    bpv(8'h03, 5'h01, 5'h00, 8'h08);
    bpv(8'h03, 5'h02, 5'h01, 8'h00);
    u_cpu.rd(8'h77, d);
    chk(d, 8'h03);
    u_cpu.rd(8'hA0, d);
    chk(d, 8'h00);
    u_cpu.wr(8'h75, 8'h03);
    u_cpu.rd(8'h75, d);
    chk(d, 8'h03);
    u_cpu.wr(8'h76, 8'hAA);
    u_cpu.wr(8'h76, 8'hBB);
    chk(tx_byte, 8'h01);
    u_cpu.wr(8'h75, 8'h02);
    u_cpu.wr(8'h75, 8'h03);
    u_cpu.rd(8'h76, d);
    chk(d, 8'hAA);
    u_cpu.rd(8'h76, d);
    chk(d, 8'hBB);
    u_cpu.wr(8'h75, 8'h00);
    u_cpu.wr(8'h75, 8'h01);
    slot_pulse(8'hAA);
    slot_pulse(8'hBB);
    // mid-run reset: latches, interrupt and trace store return to reset
    // values, and the non-zero input levels raise no event afterwards
    en[0] <= 8'h80;
    wrap <= 8'h01;
    @(posedge ref_clk_i);
    wrap <= 8'h00;
    repeat (2) @(posedge ref_clk_i);
    chk({7'h00, irq_o}, 8'h01);
    rstn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    @(posedge ref_clk_i);
    chk({7'h00, irq_o}, 8'h00);
    chk(tx_byte, 8'h01);
    foreach (ra[i]) begin
      u_cpu.rd(ra[i], d);
      chk(d, 8'h00);
    end
    print_verdict();
  end
endmodule // orl_event_latches_test
